// >>> verilog/sfgu_device.sv
// Flash end: guard bitmap, guard sequences and single sector open.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - One guard bit per sector, zero protects
// - Sixteen bytes cover 128 sectors, low bit first
// - Guard read: opcode, address, byte out MSB first
// - Guard read address steps after each byte
// - Chip enable high ends a guard read
// - Guard erase needs five correct instructions
// - Host waits normal erase time after erase; here the bench waits only GUARD_WAIT_CLKS, 16 clocks
// - Guard program needs five correct instructions
// - Guard program takes one to 256 bytes
// - Host waits page program time after program; here the bench waits only GUARD_WAIT_CLKS, 16 clocks
// - Sector open is 26h with three address bytes
// - Sector open acts only inside protected block
// - Only one sector open at a time
// - Sector open ignores address bits 0 to 11
// - Other sectors of that block stay read-only
// - Sector close 24h re-protects the open sector
module sfgu_device
  import sfgu_pkg::*;
#(
  parameter logic [31:0] SEQ_OPS  = SEQ_OPS_DEF,
  parameter logic [7:0]  ERASE_OP = OP_GUARD_ERASE,
  parameter logic [7:0]  PROG_OP  = OP_GUARD_PROG
) (
  // Serial link; its clock clocks everything here.
  sfgu_link_if.dev                link,
  // Reset, synchronous to the serial clock.
  input  wire logic              rstn,
  // Block protection level from the status register.
  input  wire logic [3:0]        wgLevel,
  // Write check for the array program and erase engine.
  input  wire logic [23:0]       chkAddr,
  output logic                   writeAllow,
  // Open sector state.
  output logic                   sectorOpen,
  output logic [SECT_W-1:0]      openSector
);

  // ----------------------------------------------------------------
  // Storage and frame state
  // ----------------------------------------------------------------
  logic [7:0]          guard [GBYTES];
  logic [BITCNT_W-1:0] bitCnt;
  logic [22:0]         shIn;
  logic [7:0]          opReg;
  logic                rdGo;
  logic [GBYTE_W-1:0]  rdBase;
  logic [GBYTE_W-1:0]  rdOff;
  logic [2:0]          rdBit;
  logic [6:0]          outSh;
  logic                so;
  logic                soOe;
  logic                pgmArm;
  logic [GBYTE_W-1:0]  pgmIdx;
  logic [8:0]          pgmCnt;
  logic [2:0]          seqStep;
  logic [7:0]          curByte;
  logic [23:0]         curAddr;
  logic                opcDone;
  logic                addrDone;
  logic                pgmByteDone;
  logic                seqLast;

  assign curByte  = {shIn[6:0], link.serialDataIn};
  assign curAddr  = {shIn, link.serialDataIn};
  assign opcDone  = (bitCnt == OPC_LAST);
  assign addrDone = (bitCnt == ADDR_LAST);
  assign seqLast  = (seqStep == 3'(SEQ_LEN - 1));
  // A data byte lands on every eighth bit after the address.
  assign pgmByteDone = pgmArm && (bitCnt > ADDR_LAST)
                       && (bitCnt[2:0] == 3'h7)
                       && (pgmCnt < PROG_MAX);

  assign link.serialDataOut   = so;
  assign link.serialDataOutOe = soOe;

  // A block counts as protected when the level reaches down to it.
  function automatic logic blockProt(input logic [3:0]       lvl,
                                     input logic [BLK_W-1:0] blk);
    blockProt = ({2'h0, blk} + {1'h0, lvl}) >= BLK_LIMIT;
  endfunction

  // Guard bit of the sector that holds an array address.
  function automatic logic guardBit(input logic [23:0] a);
    logic [SECT_W-1:0] sec;
    sec      = a[SECT_LO +: SECT_W];
    guardBit = guard[sec[SECT_W-1:3]][sec[2:0]];
  endfunction

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  // Chip enable high clears the frame at once, since the serial
  // clock may stop as soon as the frame ends.
  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      bitCnt <= '0;
      shIn   <= '0;
      opReg  <= '0;
      rdGo   <= 1'b0;
      rdBase <= '0;
      pgmArm <= 1'b0;
      pgmIdx <= '0;
      pgmCnt <= '0;
    end else begin
      shIn <= curAddr[22:0];
      if (bitCnt != '1) begin
        bitCnt <= bitCnt + 1'b1;
      end
      if (opcDone) begin
        opReg  <= curByte;
        pgmArm <= seqLast && (curByte == PROG_OP);
      end
      if (addrDone && (opReg == OP_GUARD_READ)) begin
        rdGo   <= 1'b1;
        rdBase <= curAddr[GBYTE_W-1:0];
      end
      if (addrDone) begin
        pgmIdx <= curAddr[GBYTE_W-1:0];
      end
      if (pgmByteDone) begin
        pgmIdx <= pgmIdx + 1'b1;
        pgmCnt <= pgmCnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Guard sequence tracking
  // ----------------------------------------------------------------
  // Each frame's opcode must match the next expected step; any other
  // opcode drops the sequence, so a broken one never acts.
  always_ff @(posedge link.sck) begin
    if (!rstn) begin
      seqStep <= '0;
    end else if (!link.csN && opcDone) begin
      if (!seqLast && (curByte == SEQ_OPS[seqStep*8 +: 8])) begin
        seqStep <= seqStep + 1'b1;
      end else begin
        seqStep <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Guard bitmap
  // ----------------------------------------------------------------
  // Programming only clears bits, as in the array; erase sets all.
  always_ff @(posedge link.sck) begin
    if (!rstn) begin
      for (int i = 0; i < GBYTES; i++) begin
        guard[i] <= GUARD_RESET;
      end
    end else if (!link.csN && opcDone && seqLast
                 && (curByte == ERASE_OP)) begin
      for (int i = 0; i < GBYTES; i++) begin
        guard[i] <= GUARD_RESET;
      end
    end else if (!link.csN && pgmByteDone) begin
      guard[pgmIdx] <= guard[pgmIdx] & curByte;
    end
  end

  // ----------------------------------------------------------------
  // Sector open and close
  // ----------------------------------------------------------------
  // A second open while one is held is dropped rather than replacing
  // the first, so the host must close first.
  always_ff @(posedge link.sck) begin
    if (!rstn) begin
      sectorOpen <= 1'b0;
      openSector <= '0;
    end else if (!link.csN) begin
      if (opcDone && (curByte == OP_SECT_CLOSE)) begin
        sectorOpen <= 1'b0;
      end else if (addrDone && (opReg == OP_SECT_OPEN)
                   && !sectorOpen
                   && blockProt(wgLevel, curAddr[BLK_LO +: BLK_W])) begin
        sectorOpen <= 1'b1;
        openSector <= curAddr[SECT_LO +: SECT_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write permission for the array engine
  // ----------------------------------------------------------------
  // A clear guard bit wins even over an open sector; only the open
  // sector itself escapes block protection.
  always_ff @(posedge link.sck) begin
    if (!rstn) begin
      writeAllow <= 1'b0;
    end else begin
      writeAllow <= guardBit(chkAddr)
        && (!blockProt(wgLevel, chkAddr[BLK_LO +: BLK_W])
            || (sectorOpen
                && (openSector == chkAddr[SECT_LO +: SECT_W])));
    end
  end

  // ----------------------------------------------------------------
  // Guard read output
  // ----------------------------------------------------------------
  // Bits change on the falling edge and the host takes them at the next
  // falling edge, one full period later; chip enable high releases the line.
  always_ff @(negedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      so    <= 1'b0;
      soOe  <= 1'b0;
      outSh <= '0;
      rdBit <= '0;
      rdOff <= '0;
    end else if (rdGo) begin
      soOe  <= 1'b1;
      rdBit <= rdBit + 1'b1;
      if (rdBit == 3'h0) begin
        so    <= guard[rdBase + rdOff][7];
        outSh <= guard[rdBase + rdOff][6:0];
      end else begin
        so    <= outSh[6];
        outSh <= {outSh[5:0], 1'b0};
      end
      if (rdBit == 3'h7) begin
        rdOff <= rdOff + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verilog/sfgu_pkg.sv
// Shared constants for the sector guard serial link, both ends.
package sfgu_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_SECT_OPEN   = 8'h26;
  localparam logic [7:0]  OP_SECT_CLOSE  = 8'h24;
  localparam logic [7:0]  OP_GUARD_READ  = 8'h48;
  // Four lead-in opcodes of the guard sequence, first in the low byte.
  localparam logic [31:0] SEQ_OPS_DEF    = 32'h55AA_3CC3;
  localparam logic [7:0]  OP_GUARD_ERASE = 8'h6E;
  localparam logic [7:0]  OP_GUARD_PROG  = 8'h6F;
  localparam int          SEQ_LEN        = 5;

  // ----------------------------------------------------------------
  // Array and guard map geometry
  // ----------------------------------------------------------------
  localparam int          SECT_W       = 7;
  localparam int          SECT_LO      = 12;
  localparam int          BLK_W        = 3;
  localparam int          BLK_LO       = 16;
  localparam logic [4:0]  BLK_LIMIT    = 5'h08;
  localparam int          GBYTES       = 16;
  localparam int          GBYTE_W      = 4;
  localparam logic [7:0]  GUARD_RESET  = 8'hFF;
  localparam logic [8:0]  PROG_MAX     = 9'h100;

  // ----------------------------------------------------------------
  // Frame bit positions
  // ----------------------------------------------------------------
  localparam int          BITCNT_W     = 12;
  localparam logic [11:0] OPC_LAST     = 12'h007;
  localparam logic [11:0] ADDR_LAST    = 12'h01F;

  // ----------------------------------------------------------------
  // Host timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS        = 40;
  localparam int          T_CEH_NS      = 25;
  localparam int          CEH_RAW       = (T_CEH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CEH_CLKS      = (CEH_RAW < 1) ? 1 : CEH_RAW;
  localparam int          SCK_HALF_CLKS = 2;
  // Guard erase and program finish inside their own frame here, so the
  // host's wait after them is only a short nominal gap.
  localparam int          GUARD_WAIT_CLKS = 16;

  // ----------------------------------------------------------------
  // Host registers and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_ADDR      = 4'h4;
  localparam logic [3:0]  REG_DATA      = 4'h8;
  localparam logic [3:0]  REG_STAT      = 4'hC;
  localparam int          CTRL_ADDR_BIT = 8;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_HOLD     = 1;
  localparam int          STAT_FRAME    = 2;
  localparam int          STAT_END_BIT  = 0;

endpackage

// >>> verilog/sfgu_link_if.sv
// Serial link between the host controller and the flash guard logic.
`timescale 1ns/1ps
`default_nettype none

interface sfgu_link_if;
  logic sck;
  logic csN;
  logic serialDataIn;
  logic serialDataOut;
  logic serialDataOutOe;
  logic soLine;

  // The output line idles high through a pull-up when undriven.
  assign soLine = serialDataOutOe ? serialDataOut : 1'b1;

  modport dev (
    input  sck,
    input  csN,
    input  serialDataIn,
    output serialDataOut,
    output serialDataOutOe
  );

  modport host (
    output sck,
    output csN,
    output serialDataIn,
    input  soLine
  );
endinterface

`default_nettype wire

// >>> verilog/sfgu_host.sv
// Host end: Wishbone registers driving serial frames to the flash.
`timescale 1ns/1ps
`default_nettype none

module sfgu_host
  import sfgu_pkg::*;
#(
  parameter int HALF_CLKS = SCK_HALF_CLKS
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone classic slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial link; this end makes the serial clock.
  sfgu_link_if.host          link
);

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_HOLD, H_GAP} sfgu_hst_e;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sfgu_hst_e   state;
  logic [3:0]  divCnt;
  logic [5:0]  bitsLeft;
  logic [31:0] sh;
  logic [7:0]  rxByte;
  logic [23:0] addrReg;
  logic [3:0]  gapCnt;
  logic        sck;
  logic        csN;
  logic        mosi;
  logic        misoMeta;
  logic        misoSync;
  logic        wbGo;
  logic        wrGo;

  assign wbGo = cyc_i && stb_i && !ack_o && (sel_i != 4'h0);
  assign wrGo = wbGo && we_i;

  assign link.sck          = sck;
  assign link.csN          = csN;
  assign link.serialDataIn = mosi;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state: ack rises the cycle after the request and drops
  // the cycle after; unmapped offsets read zero and ignore writes.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        unique case (adr_i)
          REG_ADDR: dat_o <= {8'h00, addrReg};
          REG_DATA: dat_o <= {24'h0, rxByte};
          REG_STAT: dat_o <= {29'h0, !csN, state == H_HOLD,
                              state == H_SHIFT};
          default:  dat_o <= '0;
        endcase
      end
    end
  end

  // Address register.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addrReg <= '0;
    end else if (wrGo && (adr_i == REG_ADDR)) begin
      addrReg <= dat_i[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Return line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      misoMeta <= 1'b1;
      misoSync <= 1'b1;
    end else begin
      misoMeta <= link.soLine;
      misoSync <= misoMeta;
    end
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // The return bit is taken at the falling serial edge; the flash
  // moved it one full serial period before, which covers the two
  // synchroniser stages as long as HALF_CLKS is at least two.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= H_IDLE;
      divCnt   <= '0;
      bitsLeft <= '0;
      sh       <= '0;
      rxByte   <= '0;
      gapCnt   <= '0;
      sck      <= 1'b0;
      csN      <= 1'b1;
      mosi     <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (wrGo && (adr_i == REG_CTRL)) begin
            csN      <= 1'b0;
            sh       <= {dat_i[7:0], addrReg};
            mosi     <= dat_i[7];
            bitsLeft <= dat_i[CTRL_ADDR_BIT] ? 6'h20 : 6'h08;
            divCnt   <= '0;
            state    <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (divCnt == 4'(HALF_CLKS - 1)) begin
            divCnt <= '0;
            sck    <= !sck;
            if (sck) begin
              rxByte   <= {rxByte[6:0], misoSync};
              sh       <= {sh[30:0], 1'b0};
              mosi     <= sh[30];
              bitsLeft <= bitsLeft - 1'b1;
              if (bitsLeft == 6'h01) begin
                state <= H_HOLD;
              end
            end
          end else begin
            divCnt <= divCnt + 1'b1;
          end
        end
        H_HOLD: begin
          if (wrGo && (adr_i == REG_DATA)) begin
            sh       <= {dat_i[7:0], 24'h0};
            mosi     <= dat_i[7];
            bitsLeft <= 6'h08;
            divCnt   <= '0;
            state    <= H_SHIFT;
          end else if (wrGo && (adr_i == REG_STAT)
                       && dat_i[STAT_END_BIT]) begin
            csN    <= 1'b1;
            gapCnt <= '0;
            state  <= H_GAP;
          end
        end
        H_GAP: begin
          // Keeps chip enable high for its least time between frames.
          if (gapCnt == 4'(CEH_CLKS - 1)) begin
            state <= H_IDLE;
          end else begin
            gapCnt <= gapCnt + 1'b1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> bench/sfgu_assertions.sv
// Link checker for the sector guard serial interface.
`timescale 1ns/1ps
`default_nettype none

module sfgu_assertions
  import sfgu_pkg::*;
(
  // Link signals.
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic serialDataIn,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutOe,
  input  wire logic soLine,
  // Device reset, synchronous to the link clock.
  input  wire logic rstn
);
  logic [11:0] bitCnt;
  logic [7:0]  opcode;
  logic        isRead;

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  // Bits seen in this frame; chip enable high clears it at once, since
  // the link clock stands still between frames.
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      bitCnt <= 12'h000;
    end else if (bitCnt != 12'hFFF) begin
      bitCnt <= bitCnt + 12'h001;
    end
  end

  // Opcode arrives MSB first over the first eight bits.
  always_ff @(posedge sck) begin
    if (bitCnt <= OPC_LAST) begin
      opcode <= {opcode[6:0], serialDataIn};
    end
  end

  assign isRead = (opcode == OP_GUARD_READ);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sck); endclocking
  default disable iff (!rstn);

  property p_quiet_cmd;
    bitCnt <= ADDR_LAST |-> !serialDataOutOe;
  endproperty
  a_quiet_cmd: assert property (p_quiet_cmd)
    else $error("output driven during command bits");

  property p_other_ops;
    bitCnt > ADDR_LAST && !isRead |-> !serialDataOutOe;
  endproperty
  a_other_ops: assert property (p_other_ops)
    else $error("output driven outside a guard read");

  property p_read_drives;
    bitCnt > ADDR_LAST && isRead |-> serialDataOutOe && soLine == serialDataOut;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("guard read data not driven");

  property p_drive_start;
    $rose(serialDataOutOe) |-> bitCnt == 12'h020 && isRead;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("output started at the wrong bit");

  property p_drive_end;
    $fell(serialDataOutOe) |-> bitCnt == 12'h000;
  endproperty
  a_drive_end: assert property (p_drive_end)
    else $error("output released inside a frame");

  property p_framed;
    !csN;
  endproperty
  a_framed: assert property (p_framed)
    else $error("link clock edge while deselected");

  property p_stream;
    bitCnt == 12'h020 && isRead |-> serialDataOutOe [*8];
  endproperty
  a_stream: assert property (p_stream)
    else $error("guard byte not driven whole");

  property p_reset_quiet;
    $rose(rstn) |-> !serialDataOutOe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output driven after reset");
endmodule

`default_nettype wire

// >>> bench/sfgu_tb.sv
// Testbench joining host and flash ends of the sector guard link.
`timescale 1ns/1ps
`default_nettype none

module sfgu_tb
  import sfgu_pkg::*;
();
  typedef struct {
    logic [3:0]  lvl;
    logic [23:0] adr;
    logic        exp;
  } sfgu_row_s;

  logic              clk;
  logic              rstn;
  logic              devRstn;
  logic              cyc;
  logic              stb;
  logic              we;
  logic [3:0]        adr;
  logic [31:0]       wdat;
  logic [31:0]       rdat;
  logic              ack;
  logic [3:0]        wgLevel;
  logic [23:0]       chkAddr;
  logic              writeAllow;
  logic              sectorOpen;
  logic [SECT_W-1:0] openSector;
  logic [7:0]        txb [4];
  logic [7:0]        rxb [4];
  int                numErrors;
  int                checkCount;
  // Write permission with sectors 0 and 15 guarded and no sector open.
  sfgu_row_s         rows [7] = '{
    '{4'h0, 24'h000000, 1'b0}, '{4'h0, 24'h001000, 1'b1},
    '{4'h0, 24'h00F000, 1'b0}, '{4'h0, 24'h010000, 1'b1},
    '{4'h8, 24'h001000, 1'b0}, '{4'h4, 24'h041000, 1'b0},
    '{4'h4, 24'h031000, 1'b1}};

  // ----------------------------------------------------------------
  // Ends, link and checker
  // ----------------------------------------------------------------
  sfgu_link_if lnk ();
  sfgu_host i_sfgu_host (.clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .link(lnk));
  sfgu_device i_sfgu_device (.link(lnk), .rstn(devRstn), .wgLevel(wgLevel),
    .chkAddr(chkAddr), .writeAllow(writeAllow), .sectorOpen(sectorOpen),
    .openSector(openSector));
  sfgu_assertions i_sfgu_assertions (.sck(lnk.sck), .csN(lnk.csN),
    .serialDataIn(lnk.serialDataIn), .serialDataOut(lnk.serialDataOut),
    .serialDataOutOe(lnk.serialDataOutOe), .soLine(lnk.soLine),
    .rstn(devRstn));

  // Free-running system clock.
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    numErrors++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask

  task automatic chkFlag(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask

  task automatic final_report();
    if (numErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) fail("no bus answer");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] q;
    int          n;
    n = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 100);
    if (q[b] !== v) fail("status wait expired");
  endtask

  // Whole frame: opcode, optional address, n bytes each way, then close.
  task automatic frame(input logic [7:0] op, input logic ad,
                       input logic [23:0] a, input int n);
    logic [31:0] q;
    wb(1'b1, REG_ADDR, {8'h00, a}, q);
    wb(1'b1, REG_CTRL, {23'h0, ad, op}, q);
    poll(STAT_HOLD, 1'b1);
    for (int i = 0; i < n; i++) begin
      wb(1'b1, REG_DATA, {24'h0, txb[i]}, q);
      poll(STAT_HOLD, 1'b1);
      wb(1'b0, REG_DATA, 32'h0, q);
      rxb[i] = q[7:0];
    end
    wb(1'b1, REG_STAT, 32'h1, q);
    poll(STAT_FRAME, 1'b0);
  endtask

  // A no-op frame: the device only sees its inputs on link clock edges.
  task automatic tick();
    frame(8'h00, 1'b0, 24'h0, 0);
  endtask

  // Lead-in frames of the guard sequence; step bad is spoiled.
  task automatic seq(input int bad);
    for (int i = 0; i < 4; i++) begin
      frame(i == bad ? 8'h00 : SEQ_OPS_DEF[8*i +: 8], 1'b0, 24'h0, 0);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    devRstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    wgLevel = 4'h0;
    chkAddr = 24'h0;
    numErrors = 0;
    checkCount = 0;
    // Dummy bytes of read frames stay defined on the link.
    txb = '{4{8'h00}};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // The device resets on link clock edges, so one frame carries it.
    tick();
    devRstn <= 1'b1;
    frame(OP_GUARD_READ, 1'b1, 24'h00000F, 2);
    chkByte(rxb[0], GUARD_RESET);
    chkByte(rxb[1], GUARD_RESET);
    txb[0] = 8'hFE;
    txb[1] = 8'h7F;
    seq(4);
    frame(OP_GUARD_PROG, 1'b1, 24'h0, 2);
    repeat (GUARD_WAIT_CLKS) @(posedge clk);
    frame(OP_GUARD_READ, 1'b1, 24'h0, 3);
    chkByte(rxb[0], 8'hFE);
    chkByte(rxb[1], 8'h7F);
    chkByte(rxb[2], GUARD_RESET);
    foreach (rows[i]) begin
      wgLevel <= rows[i].lvl;
      chkAddr <= rows[i].adr;
      tick();
      chkFlag(writeAllow, rows[i].exp);
    end
    // A spoiled program and a spoiled erase both leave the map alone.
    txb[0] = 8'h00;
    seq(1);
    frame(OP_GUARD_PROG, 1'b1, 24'h0, 1);
    seq(2);
    frame(OP_GUARD_ERASE, 1'b0, 24'h0, 0);
    frame(OP_GUARD_READ, 1'b1, 24'h0, 1);
    chkByte(rxb[0], 8'hFE);
    // Read cut short right after its address.
    frame(OP_GUARD_READ, 1'b1, 24'h0, 0);
    wgLevel <= 4'h0;
    frame(OP_SECT_OPEN, 1'b1, 24'h023ABC, 0);
    chkFlag(sectorOpen, 1'b0);
    wgLevel <= 4'h8;
    chkAddr <= 24'h023000;
    frame(OP_SECT_OPEN, 1'b1, 24'h023ABC, 0);
    frame(OP_SECT_OPEN, 1'b1, 24'h045000, 0);
    tick();
    chkFlag(sectorOpen, 1'b1);
    chkByte({1'b0, openSector}, 8'h23);
    chkFlag(writeAllow, 1'b1);
    chkAddr <= 24'h024000;
    tick();
    chkFlag(writeAllow, 1'b0);
    chkAddr <= 24'h023000;
    frame(OP_SECT_CLOSE, 1'b0, 24'h0, 0);
    tick();
    chkFlag(writeAllow, 1'b0);
    chkFlag(sectorOpen, 1'b0);
    frame(OP_SECT_OPEN, 1'b1, 24'h045000, 0);
    chkByte({1'b0, openSector}, 8'h45);
    seq(4);
    frame(OP_GUARD_ERASE, 1'b0, 24'h0, 0);
    repeat (GUARD_WAIT_CLKS) @(posedge clk);
    frame(OP_GUARD_READ, 1'b1, 24'h0, 1);
    chkByte(rxb[0], GUARD_RESET);
    // Clear guard byte 0 so the reset below has something to restore.
    seq(4);
    frame(OP_GUARD_PROG, 1'b1, 24'h0, 1);
    repeat (GUARD_WAIT_CLKS) @(posedge clk);
    // A second reset in mid-run drops the open sector.
    devRstn <= 1'b0;
    tick();
    devRstn <= 1'b1;
    chkFlag(sectorOpen, 1'b0);
    frame(OP_GUARD_READ, 1'b1, 24'h0, 1);
    chkByte(rxb[0], GUARD_RESET);
    final_report();
  end

  // Cuts a hung run short; the tests need well under this many cycles.
  initial begin
    repeat (60000) @(posedge clk);
    fail("run timed out");
    final_report();
  end
endmodule

`default_nettype wire
